// file: iem_enable_mask.sv
// interrupt enable registers and masked request generation
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
module iem_enable_mask (
    input  wire logic                       ref_clk,
    input  wire logic                       reset,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [iem_pkg::ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    input  wire logic [iem_pkg::NFLAG-1:0]  hw_flag_set,
    input  wire logic [iem_pkg::NSRC-1:0]   service_enter,
    output logic      [iem_pkg::NSRC-1:0]   irq_req,
    output logic      [iem_pkg::NFLAG-1:0]  flags_out
);
    typedef struct packed {
        logic [7:0]                 prim;
        logic [7:0]                 ext;
        logic [iem_pkg::TWO_W-1:0]  two;
        logic [iem_pkg::NSRC-1:0]   req;
        logic [31:0]                dat;
    } iem_state_t;

    iem_state_t s_q;
    iem_state_t s_d;

    logic                        take;
    logic                        commit;
    logic                        wr;
    logic [7:0]                  idx;
    logic [iem_pkg::NFLAG-1:0]   flags;
    logic [iem_pkg::NFLAG-1:0]   lane_mask;
    logic [iem_pkg::NFLAG-1:0]   auto_clr;
    logic [iem_pkg::EN_W-1:0]    en_vec;
    logic [iem_pkg::NSRC-1:0]    raw;
    logic [iem_pkg::NSRC-1:0]    en;
    logic                        flag_we;
    logic                        global_en;

    iem_wb_slave u_wbs (
        .ref_clk (ref_clk),
        .reset   (reset),
        .cyc     (wb_cyc_i),
        .stb     (wb_stb_i),
        .ack_q   (wb_ack_o),
        .take    (take),
        .commit  (commit)
    );

    assign idx = wb_adr_i[iem_pkg::ADR_W-1:2];
    assign wr  = commit & wb_we_i;

    // byte lanes expand to a bit mask for the flag word
    assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    assign flag_we = wr & (idx == iem_pkg::IDX_FLAG); // R3

    // timer 2 is left out on purpose: its flag stays until software
    always_comb begin
        auto_clr = '0;
        auto_clr[iem_pkg::TMR0_FLAG] =
            service_enter[iem_pkg::TMR0_SRC]; // R23
        auto_clr[iem_pkg::TMR1_FLAG] =
            service_enter[iem_pkg::TMR1_SRC]; // R23
        auto_clr[iem_pkg::TMR3_FLAG] =
            service_enter[iem_pkg::TMR3_SRC]; // R23
    end

    iem_flag_bank u_flags (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .hw_set   (hw_flag_set),
        .sw_we    (flag_we),
        .sw_mask  (lane_mask),
        .sw_data  (wb_dat_i),
        .auto_clr (auto_clr),
        .flags_q  (flags)
    );

    assign flags_out = flags;

    assign en_vec = {5'h00, s_q.two, s_q.ext, s_q.prim};
    assign global_en = s_q.prim[iem_pkg::GLOBAL_BIT];

    // per source: any of its flags, and its own enable bit
    for (genvar k = 0; k < iem_pkg::NSRC; k++) begin : g_src
        assign raw[k] = |(flags & iem_pkg::SRC_FLAGS[k]); // R4
        assign en[k]  = en_vec[iem_pkg::SRC_EN_BIT[k]];
    end

    always_comb begin
        s_d = s_q;
        // flags are never touched by the mask, so requests stay pending
        s_d.req = raw & en & {iem_pkg::NSRC{global_en}}; // R1 R2 R24
        if (wr && wb_sel_i[0]) begin
            unique case (idx)
                iem_pkg::IDX_PRIM: s_d.prim = wb_dat_i[7:0];
                iem_pkg::IDX_EXT:  s_d.ext  = wb_dat_i[7:0];
                iem_pkg::IDX_TWO:
                    s_d.two = wb_dat_i[iem_pkg::TWO_W-1:0]; // R25
                default: ;
            endcase
        end
        if (take) begin
            // unmapped addresses still ack and read as zero
            unique case (idx)
                iem_pkg::IDX_PRIM: s_d.dat = {24'h000000, s_q.prim};
                iem_pkg::IDX_EXT:  s_d.dat = {24'h000000, s_q.ext};
                iem_pkg::IDX_TWO:
                    s_d.dat = {29'h00000000, s_q.two}; // R25
                iem_pkg::IDX_FLAG: s_d.dat = flags;
                iem_pkg::IDX_REQ:  s_d.dat = {14'h0000, s_q.req};
                default:           s_d.dat = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q.prim <= iem_pkg::PRIM_RST; // R22
            s_q.ext  <= iem_pkg::EXT_RST; // R22
            s_q.two  <= iem_pkg::TWO_RST; // R22
            s_q.req  <= iem_pkg::REQ_RST;
            s_q.dat  <= 32'h00000000;
        end else begin
            s_q <= s_d;
        end
    end

    assign irq_req  = s_q.req;
    assign wb_dat_o = s_q.dat;

    AST_GLOBAL_MASK: assert property ( // R1
        @(posedge ref_clk) disable iff (reset)
        !global_en |=> (irq_req == '0))
    else $error("request seen while global enable low");

    AST_PENDING_HELD: assert property ( // R2
        @(posedge ref_clk) disable iff (reset)
        (!global_en && raw[0] && en[0] && !flag_we)
        ##1 (global_en && en[0]) |=> irq_req[0])
    else $error("pending request not presented after enable");

    AST_SW_SET: assert property ( // R3
        @(posedge ref_clk) disable iff (reset)
        (flag_we && wb_sel_i[0] && wb_dat_i[0]) |=> flags[0])
    else $error("software write did not set flag");

    AST_REQ_FOLLOWS: assert property ( // R4
        @(posedge ref_clk) disable iff (reset)
        (global_en && raw[7] && en[7]) |=> irq_req[7])
    else $error("enabled flagged source did not request");

    AST_CONVERTER: assert property ( // R6
        @(posedge ref_clk) disable iff (reset)
        (global_en && !s_q.prim[6]) |=> !irq_req[11])
    else $error("converter request with its enable low");

    AST_BROWNOUT: assert property ( // R7
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.prim[5] && flags[17]) |=> irq_req[8])
    else $error("brown-out request missing");

    AST_UART0: assert property ( // R8
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.prim[4] && (flags[4] || flags[5]))
        |=> irq_req[4])
    else $error("uart0 request missing");

    AST_TIMERS01: assert property ( // R9
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.prim[3] && s_q.prim[1] && flags[3] && flags[1])
        |=> (irq_req[3] && irq_req[1]))
    else $error("timer0/1 request missing");

    AST_EXT_INPUTS: assert property ( // R10
        @(posedge ref_clk) disable iff (reset)
        (!s_q.prim[2] && !s_q.prim[0]) |=> (!irq_req[2] && !irq_req[0]))
    else $error("external request with enables low");

    AST_TIMER2: assert property ( // R11
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.ext[7] && flags[6]) |=> irq_req[5])
    else $error("timer2 request missing");

    AST_SPI: assert property ( // R12
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.ext[6] && (|flags[20:18])) |=> irq_req[9])
    else $error("spi request missing");

    AST_PIN: assert property ( // R17
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.ext[1] && (|flags[16:9])) |=> irq_req[7])
    else $error("pin request missing");

    AST_UART1: assert property ( // R21
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.two[0] && (flags[28] || flags[29]))
        |=> irq_req[15])
    else $error("uart1 request missing");

    AST_RESET_ZERO: assert property ( // R22
        @(posedge ref_clk)
        $fell(reset) |-> (s_q.prim == 8'h00 && s_q.ext == 8'h00
                          && s_q.two == 3'h0))
    else $error("enable registers not zero after reset");

    AST_T0_AUTOCLR: assert property ( // R23
        @(posedge ref_clk) disable iff (reset)
        (service_enter[1] && !hw_flag_set[1] && !flag_we) |=> !flags[1])
    else $error("timer0 flag survived service entry");

    AST_T2_KEEPS: assert property ( // R23
        @(posedge ref_clk) disable iff (reset)
        (flags[6] && service_enter[5] && !flag_we) |=> flags[6])
    else $error("timer2 flag cleared by service entry");

    AST_REQ_EQUATION: assert property ( // R24
        @(posedge ref_clk) disable iff (reset)
        ##1 (irq_req == $past(raw & en & {iem_pkg::NSRC{global_en}})))
    else $error("request not the gated flag OR");

    AST_TWO_UPPER: assert property ( // R25
        @(posedge ref_clk) disable iff (reset)
        (take && !wb_we_i && idx == iem_pkg::IDX_TWO)
        |=> (wb_dat_o[31:3] == '0))
    else $error("upper bits of second register not zero");

    AST_EXT0_ON: assert property ( // R10
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.prim[0] && flags[0]) |=> irq_req[0])
    else $error("external 0 request missing");

    AST_EXT1_ON: assert property ( // R10
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.prim[2] && flags[2]) |=> irq_req[2])
    else $error("external 1 request missing");

    AST_TIMER0_OFF: assert property ( // R9
        @(posedge ref_clk) disable iff (reset)
        !s_q.prim[1] |=> !irq_req[1])
    else $error("timer0 request with its enable low");

    AST_CONVERTER_ON: assert property ( // R6
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.prim[6] && flags[22]) |=> irq_req[11])
    else $error("converter request missing");

    AST_BROWNOUT_OFF: assert property ( // R7
        @(posedge ref_clk) disable iff (reset)
        !s_q.prim[5] |=> !irq_req[8])
    else $error("brown-out request with its enable low");

    AST_UART0_OFF: assert property ( // R8
        @(posedge ref_clk) disable iff (reset)
        !s_q.prim[4] |=> !irq_req[4])
    else $error("uart0 request with its enable low");

    AST_TIMER2_OFF: assert property ( // R11
        @(posedge ref_clk) disable iff (reset)
        !s_q.ext[7] |=> !irq_req[5])
    else $error("timer2 request with its enable low");

    AST_SPI_OFF: assert property ( // R12
        @(posedge ref_clk) disable iff (reset)
        !s_q.ext[6] |=> !irq_req[9])
    else $error("spi request with its enable low");

    AST_FAULT_BRAKE: assert property ( // R13
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.ext[5] && flags[27]) |=> irq_req[14])
    else $error("fault brake request missing");

    AST_WATCHDOG: assert property ( // R14
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.ext[4] && flags[21]) |=> irq_req[10])
    else $error("watchdog request missing");

    AST_PWM: assert property ( // R15
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.ext[3] && flags[26]) |=> irq_req[13])
    else $error("pwm request missing");

    AST_CAPTURE: assert property ( // R16
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.ext[2] && (|flags[25:23])) |=> irq_req[12])
    else $error("capture request missing");

    AST_CAPTURE_OFF: assert property ( // R16
        @(posedge ref_clk) disable iff (reset)
        !s_q.ext[2] |=> !irq_req[12])
    else $error("capture request with its enable low");

    AST_PIN_OFF: assert property ( // R17
        @(posedge ref_clk) disable iff (reset)
        !s_q.ext[1] |=> !irq_req[7])
    else $error("pin request with its enable low");

    AST_I2C: assert property ( // R18
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.ext[0] && (flags[7] || flags[8]))
        |=> irq_req[6])
    else $error("i2c request missing");

    AST_WAKEUP: assert property ( // R19
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.two[2] && flags[31]) |=> irq_req[17])
    else $error("wake-up timer request missing");

    AST_TIMER3: assert property ( // R20
        @(posedge ref_clk) disable iff (reset)
        (global_en && s_q.two[1] && flags[30]) |=> irq_req[16])
    else $error("timer3 request missing");

    AST_UART1_OFF: assert property ( // R21
        @(posedge ref_clk) disable iff (reset)
        !s_q.two[0] |=> !irq_req[15])
    else $error("uart1 request with its enable low");

    AST_NO_FLAG: assert property ( // R4
        @(posedge ref_clk) disable iff (reset)
        (raw == '0) |=> (irq_req == '0))
    else $error("request raised with no flag set");

    AST_HW_SET: assert property ( // R4
        @(posedge ref_clk) disable iff (reset)
        hw_flag_set[1] |=> flags[1])
    else $error("hardware set pulse did not set flag");

    AST_SW_CLEAR: assert property ( // R5
        @(posedge ref_clk) disable iff (reset)
        (flag_we && wb_sel_i[0] && !wb_dat_i[0] && !hw_flag_set[0])
        |=> !flags[0])
    else $error("software write of zero did not clear flag");

    AST_PENDING_FLAGS: assert property ( // R2
        @(posedge ref_clk) disable iff (reset)
        (!global_en && !flag_we && service_enter == '0)
        |=> ((flags & $past(flags)) == $past(flags)))
    else $error("flag lost while global enable low");

    AST_T1_AUTOCLR: assert property ( // R23
        @(posedge ref_clk) disable iff (reset)
        (service_enter[3] && !hw_flag_set[3] && !flag_we) |=> !flags[3])
    else $error("timer1 flag survived service entry");

    AST_T3_AUTOCLR: assert property ( // R23
        @(posedge ref_clk) disable iff (reset)
        (service_enter[16] && !hw_flag_set[30] && !flag_we)
        |=> !flags[30])
    else $error("timer3 flag survived service entry");

    AST_TWO_WRITE: assert property ( // R25
        @(posedge ref_clk) disable iff (reset)
        (wr && wb_sel_i[0] && idx == iem_pkg::IDX_TWO)
        |=> (s_q.two == $past(wb_dat_i[iem_pkg::TWO_W-1:0])))
    else $error("second register write did not land");
endmodule

// file: iem_pkg.sv
// constants, register map and source tables of the interrupt enable stage
// Notes on behaviour
// R1: global enable low masks every source
// R2: masked requests stay pending until global enable
// R3: software writes can set any flag
// R4: enabled source requests while its flag is 1
// R5: service routine clears flags by writing 0
// R6: primary bit 6 gates converter done flag
// R7: primary bit 5 gates brown-out flag
// R8: primary bit 4 gates uart0 tx/rx done
// R9: primary bits 3,1 gate timer1, timer0 overflow
// R10: primary bits 2,0 gate external inputs 1,0
// R11: extended bit 7 gates timer2 event flag
// R12: extended bit 6 gates any spi flag
// R13: extended bit 5 gates fault brake flag
// R14: extended bit 4 gates watchdog flag
// R15: extended bit 3 gates pwm flag
// R16: extended bit 2 gates any capture flag
// R17: extended bit 1 gates any pin flag
// R18: extended bit 0 gates i2c status/timeout
// R19: second bit 2 gates wake-up timer flag
// R20: second bit 1 gates timer3 overflow flag
// R21: second bit 0 gates uart1 tx/rx done
// R22: all enable registers reset to zero
// R23: timer 0,1,3 flags clear on service entry
// R24: request is registered OR-of-flags and both enables
// R25: second register upper five bits read zero
package iem_pkg;
    localparam int NSRC      = 18;
    localparam int NFLAG     = 32;
    localparam int EN_W      = 24;
    localparam int TWO_W     = 3;
    localparam int ADR_W     = 10;
    localparam int GLOBAL_BIT = 7;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PRIM = 8'ha8;
    localparam logic [7:0] IDX_EXT  = 8'h9b;
    localparam logic [7:0] IDX_TWO  = 8'h9c;
    localparam logic [7:0] IDX_FLAG = 8'hb0;
    localparam logic [7:0] IDX_REQ  = 8'hb1;
    localparam logic [7:0]       PRIM_RST = 8'h00;
    localparam logic [7:0]       EXT_RST  = 8'h00;
    localparam logic [TWO_W-1:0] TWO_RST  = 3'h0;
    localparam logic [31:0]      FLAG_RST = 32'h0;
    localparam logic [17:0]      REQ_RST  = 18'h0;
    // sources whose flag clears on entry to service
    localparam int TMR0_SRC  = 1;
    localparam int TMR1_SRC  = 3;
    localparam int TMR3_SRC  = 16;
    localparam int TMR0_FLAG = 1;
    localparam int TMR1_FLAG = 3;
    localparam int TMR3_FLAG = 30;
    typedef logic [NFLAG-1:0] iem_mask_t;
    // flags feeding each source, in vector order
    localparam iem_mask_t SRC_FLAGS [NSRC] = '{
        32'h00000001, // R10
        32'h00000002, // R9
        32'h00000004, // R10
        32'h00000008, // R9
        32'h00000030, // R8
        32'h00000040, // R11
        32'h00000180, // R18
        32'h0001fe00, // R17
        32'h00020000, // R7
        32'h001c0000, // R12
        32'h00200000, // R14
        32'h00400000, // R6
        32'h03800000, // R16
        32'h04000000, // R15
        32'h08000000, // R13
        32'h30000000, // R21
        32'h40000000, // R20
        32'h80000000  // R19
    };
    // enable bit of each source in {second, extended, primary}
    localparam int SRC_EN_BIT [NSRC] = '{
        0, 1, 2, 3, 4, 15, 8, 9, 5, 14, 12, 6, 10, 11, 13, 16, 17, 18
    };
endpackage

// file: iem_wb_slave.sv
// classic wishbone handshake: one-cycle ack and access strobe
`timescale 1ns/1ps
module iem_wb_slave (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic cyc,
    input  wire logic stb,
    output logic      ack_q,
    output logic      take,
    output logic      commit
);
    typedef struct packed {
        logic ack;
    } iem_wbs_t;

    iem_wbs_t s_q;
    iem_wbs_t s_d;

    always_comb begin
        s_d     = s_q;
        // ack drops the cycle after it was given
        s_d.ack = cyc & stb & ~s_q.ack;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ack_q  = s_q.ack;
    assign take   = s_d.ack;
    // writes land on the edge the master samples ack
    assign commit = cyc & stb & s_q.ack;
endmodule

// file: iem_flag_bank.sv
// interrupt flags: hardware set, software set/clear, auto clear
`timescale 1ns/1ps
module iem_flag_bank (
    input  wire logic                     ref_clk,
    input  wire logic                     reset,
    input  wire logic [iem_pkg::NFLAG-1:0] hw_set,
    input  wire logic                     sw_we,
    input  wire logic [iem_pkg::NFLAG-1:0] sw_mask,
    input  wire logic [iem_pkg::NFLAG-1:0] sw_data,
    input  wire logic [iem_pkg::NFLAG-1:0] auto_clr,
    output logic      [iem_pkg::NFLAG-1:0] flags_q
);
    typedef struct packed {
        logic [iem_pkg::NFLAG-1:0] flags;
    } iem_fb_t;

    iem_fb_t s_q;
    iem_fb_t s_d;
    logic [iem_pkg::NFLAG-1:0] clr;
    logic [iem_pkg::NFLAG-1:0] set;

    always_comb begin
        s_d     = s_q;
        set     = hw_set | ({iem_pkg::NFLAG{sw_we}} & sw_mask & sw_data); // R3
        clr     = ({iem_pkg::NFLAG{sw_we}} & sw_mask & ~sw_data) | auto_clr;
        // a set in the clearing cycle wins, so no event is lost
        s_d.flags = set | (s_q.flags & ~clr);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q.flags <= iem_pkg::FLAG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign flags_q = s_q.flags;
endmodule

// file: iem_periph_model.sv
// far side: peripheral flag pulses and cpu service entry
`timescale 1ns/1ps
module iem_periph_model (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [31:0] fire,
    input  wire logic        svc_on,
    input  wire logic [17:0] irq_req,
    output logic      [31:0] hw_flag_set,
    output logic      [17:0] service_enter
);
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hw_flag_set   <= 32'h0;
            service_enter <= 18'h0;
        end else begin
            hw_flag_set <= fire;
            // one-cycle entry pulse per pending request, gap between
            service_enter <= svc_on ? (irq_req & ~service_enter) : 18'h0;
        end
    end
endmodule

// file: test_interrupt_enable_masking.sv
// self-checking bench for the interrupt enable and masking stage
`timescale 1ns/1ps
module test_interrupt_enable_masking;
    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        wb_cyc  = 1'b0;
    logic        wb_stb  = 1'b0;
    logic        wb_we   = 1'b0;
    logic [9:0]  wb_adr  = 10'h0;
    logic [3:0]  wb_sel  = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_rd;
    logic        wb_ack;
    logic [31:0] fire    = 32'h0;
    logic        svc_on  = 1'b0;
    logic [31:0] hw_set;
    logic [17:0] svc;
    logic [17:0] irq_req;
    logic [31:0] flags_out;
    int          err_total  = 0;
    int          n_compared = 0;
    int          cyc_cnt    = 0;
    // highest flag bit of each source and its enable bit position
    int fl [18] = '{0,1,2,3,5,6,8,16,17,20,21,22,25,26,27,29,30,31};
    int en [18] = '{0,1,2,3,4,15,8,9,5,14,12,6,10,11,13,16,17,18};

    always #5 ref_clk = ~ref_clk;

    iem_enable_mask iem_enable_mask_inst (
        .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_rd),
        .wb_ack_o(wb_ack), .hw_flag_set(hw_set), .service_enter(svc),
        .irq_req(irq_req), .flags_out(flags_out)
    );

    iem_periph_model iem_periph_model_inst (
        .ref_clk(ref_clk), .reset(reset), .fire(fire), .svc_on(svc_on),
        .irq_req(irq_req), .hw_flag_set(hw_set), .service_enter(svc)
    );

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask

    // entered just after a rising edge; ack sampled at rising edges only
    task automatic wb_xfer(input logic we, input logic [7:0] idx,
                           input logic [31:0] d, output logic [31:0] q);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= {idx, 2'b00};
        wb_sel   <= 4'hf;
        wb_dat_w <= d;
        @(posedge ref_clk);
        while (wb_ack !== 1'b1) @(posedge ref_clk);
        q = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic settle;
        repeat (3) @(posedge ref_clk);
    endtask

    // bit 7 of e is ignored; global enable comes from g
    task automatic set_en(input logic [23:0] e, input logic g);
        logic [31:0] q;
        wb_xfer(1'b1, iem_pkg::IDX_PRIM, {24'h0, g, e[6:0]}, q);
        wb_xfer(1'b1, iem_pkg::IDX_EXT, {24'h0, e[15:8]}, q);
        wb_xfer(1'b1, iem_pkg::IDX_TWO, {24'h0, e[23:16]}, q);
        settle();
    endtask

    initial begin
        logic [31:0] q;
        logic [31:0] b;
        logic [23:0] e;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        wb_xfer(1'b0, iem_pkg::IDX_PRIM, 32'h0, q);
        chk("prim_rst", q, 32'h0);
        wb_xfer(1'b0, iem_pkg::IDX_EXT, 32'h0, q);
        chk("ext_rst", q, 32'h0);
        wb_xfer(1'b0, iem_pkg::IDX_TWO, 32'h0, q);
        chk("two_rst", q, 32'h0);
        wb_xfer(1'b1, iem_pkg::IDX_TWO, 32'hff, q);
        wb_xfer(1'b0, iem_pkg::IDX_TWO, 32'h0, q);
        chk("two_upper", q, 32'h7);
        wb_xfer(1'b1, iem_pkg::IDX_PRIM, 32'h5a, q);
        wb_xfer(1'b0, iem_pkg::IDX_PRIM, 32'h0, q);
        chk("prim_rw", q, 32'h5a);
        wb_xfer(1'b1, iem_pkg::IDX_EXT, 32'ha5, q);
        wb_xfer(1'b0, iem_pkg::IDX_EXT, 32'h0, q);
        chk("ext_rw", q, 32'ha5);
        wb_xfer(1'b0, 8'h10, 32'h0, q);
        chk("unmapped", q, 32'h0);
        // each source: gating by own bit and by global bit
        for (int k = 0; k < 18; k++) begin
            b = 32'h1 << fl[k];
            e = 24'h1 << en[k];
            set_en(~e, 1'b1);
            if (k % 2 == 0) begin
                wb_xfer(1'b1, iem_pkg::IDX_FLAG, b, q);
            end else begin
                fire <= b;
                @(posedge ref_clk);
                fire <= 32'h0;
            end
            settle();
            chk("flag_set", flags_out, b);
            chk("own_off", {14'h0, irq_req}, 32'h0);
            set_en(e, 1'b1);
            chk("irq_on", {14'h0, irq_req}, 32'h1 << k);
            set_en(e, 1'b0);
            chk("glob_off", {14'h0, irq_req}, 32'h0);
            chk("pending", flags_out, b);
            set_en(e, 1'b1);
            chk("glob_on", {14'h0, irq_req}, 32'h1 << k);
            wb_xfer(1'b0, iem_pkg::IDX_REQ, 32'h0, q);
            chk("req_reg", q, 32'h1 << k);
            chk("glob_on3", {14'h0, irq_req}, 32'h1 << k);
            wb_xfer(1'b0, iem_pkg::IDX_FLAG, 32'h0, q);
            chk("flag_reg", q, b);
            wb_xfer(1'b1, iem_pkg::IDX_FLAG, 32'h0, q);
            settle();
            chk("sw_clear", {14'h0, irq_req}, 32'h0);
        end
        // service entry clears timers 0, 1, 3 but not timer 2
        set_en(24'hffffff, 1'b1);
        svc_on <= 1'b1;
        fire   <= 32'h4000004a;
        @(posedge ref_clk);
        fire   <= 32'h0;
        repeat (8) @(posedge ref_clk);
        chk("auto_clr", flags_out, 32'h00000040);
        chk("t2_stays", {14'h0, irq_req}, 32'h20);
        svc_on <= 1'b0;
        give_verdict();
    end
endmodule
